//--- rtl/sid_defines.svh
// constants for the serial id i2c device and its bus master
`ifndef SID_DEFINES_SVH
`define SID_DEFINES_SVH

// =====================================================================
// clock and timing
`define SID_CLK_NS        5
`define SID_TIMEOUT_NS    25000000
`define SID_TIMEOUT_CYC   (`SID_TIMEOUT_NS / `SID_CLK_NS)
`define SID_DIV_RESET     16'h007D

// =====================================================================
// device identity and memory map
`define SID_SLAVE_ADDR    7'h50
// arbitrary value
`define SID_FAMILY_CODE   8'hA5
// arbitrary value
`define SID_SERIAL_NUM    48'h0000_0000_0001
`define SID_CRC_POLY      8'h8C
`define SID_LAST_LOC      8'h08
`define SID_CTRL_LOC      4'h8
`define SID_PTR_RESET     4'h0
`define SID_CTRL_RESET    1'b1

// =====================================================================
// master register offsets and fields
`define SID_REG_CMD       8'h00
`define SID_REG_TXD       8'h04
`define SID_REG_STAT      8'h08
`define SID_REG_DIV       8'h0C
`define SID_CMD_START     0
`define SID_CMD_WRITE     1
`define SID_CMD_READ      2
`define SID_CMD_STOP      3
`define SID_CMD_NACK      4
`define SID_STAT_BUSY     8
`define SID_STAT_NACK     9
`define SID_RESP_OKAY     2'h0
`define SID_RESP_SLVERR   2'h2

`endif

//--- rtl/sid_pkg.sv
// types shared by the serial id i2c ends
package sid_pkg;
	typedef enum logic [2:0] {
		DEV_IDLE = 3'h0,
		DEV_RX   = 3'h1,
		DEV_ACK  = 3'h2,
		DEV_TX   = 3'h3,
		DEV_MACK = 3'h4
	} sid_dev_state_t;

	typedef enum logic [1:0] {
		PH_SLA  = 2'h0,
		PH_PTR  = 2'h1,
		PH_DATA = 2'h2
	} sid_phase_t;

	typedef enum logic [1:0] {
		H_IDLE  = 2'h0,
		H_START = 2'h1,
		H_BITS  = 2'h2,
		H_STOP  = 2'h3
	} sid_host_state_t;
endpackage

//--- rtl/sid_i2c_if.sv
// i2c wire pair joining device end and bus master end
`timescale 1ns/1ps
interface sid_i2c_if;
	logic host_scl_o;
	logic host_scl_oe_n;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic scl;
	logic sda;

	// =================================================================
	// wired-and with pull-up
	assign scl = host_scl_oe_n | host_scl_o;
	assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

	modport dev (
		input  scl,
		input  sda,
		output dev_sda_o,
		output dev_sda_oe_n
	);

	modport host (
		input  scl,
		input  sda,
		output host_scl_o,
		output host_scl_oe_n,
		output host_sda_o,
		output host_sda_oe_n
	);
endinterface

//--- rtl/sid_bus_sampler.sv
// scl/sda edge and start/stop detector
`timescale 1ns/1ps
module sid_bus_sampler (
	input  wire logic core_clk,
	input  wire logic rstn,
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_rise,
	output logic      scl_fall,
	output logic      sda_rise,
	output logic      start_det,
	output logic      stop_det
);
	logic scl_q;
	logic sda_q;

	// =================================================================
	// previous sample
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	// =================================================================
	// edges and conditions
	assign scl_rise  = scl & ~scl_q;
	assign scl_fall  = ~scl & scl_q;
	assign sda_rise  = sda & ~sda_q;
	assign start_det = scl & scl_q & sda_q & ~sda;
	assign stop_det  = scl & scl_q & ~sda_q & sda;
endmodule

//--- rtl/sid_i2c_dev.sv
// i2c slave end of the serial id device with 9-byte memory
`timescale 1ns/1ps
`include "sid_defines.svh"
// Overview of operation
// - always acknowledge own slave address
// - refused byte: no ack, sda released
// - master restarts after a missing ack
// - master ends read with no ack
// - master nack stops transmit, releases sda
// - nine bytes: eight rom, one control
// - write: first byte sets pointer
// - ack pointer values zero through eight
// - rom data writes dropped, not acked
// - write pointer advances, wraps eight to zero
// - read returns bytes from pointer
// - pointer is zero after reset
// - read pointer advances, wraps eight to zero
// - master sets pointer before chosen read
// - timeout reset keeps the pointer
// - control byte write acked and stored
// - scl is input only, no stretching
// - sda only driven low or released
// - control bit zero selects smbus mode
// - smbus stuck bus resets the interface
// - rom: family, serial lsb first, crc
module sid_i2c_dev #(
	parameter int          TIMEOUT_CYC = `SID_TIMEOUT_CYC,
	parameter logic [6:0]  SLAVE_ADDR  = `SID_SLAVE_ADDR,
	parameter logic [7:0]  FAMILY_CODE = `SID_FAMILY_CODE,
	parameter logic [47:0] SERIAL_NUM  = `SID_SERIAL_NUM
) (
	input  wire logic  core_clk,
	input  wire logic  rstn,
	sid_i2c_if.dev     bus,
	output logic       smbus_mode_select,
	output logic [3:0] addr_ptr,
	output logic       bus_timeout
);
	// =================================================================
	// parameter check
	if (TIMEOUT_CYC < 2) begin : g_bad_timeout
		$error("timeout must be at least two cycles");
	end

	// =================================================================
	// rom contents
	function automatic logic [7:0] sid_crc8(input logic [55:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 56; i++) begin
			c = (c[0] ^ d[i]) ? ((c >> 1) ^ `SID_CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

	localparam logic [63:0] ROM_BITS = {sid_crc8({SERIAL_NUM, FAMILY_CODE}),
		SERIAL_NUM, FAMILY_CODE};

	sid_pkg::sid_dev_state_t st_q;
	sid_pkg::sid_phase_t     ph_q;
	logic [3:0]              bit_q;
	logic [7:0]              shift_q;
	logic [3:0]              ptr_q;
	logic                    ctrl_q;
	logic                    rd_q;
	logic                    bad_ptr_q;
	logic                    sda_oe_n_q;
	logic                    sda_o_q;
	logic [31:0]             tmo_cnt_q;
	logic                    tmo_q;

	logic scl_rise;
	logic scl_fall;
	logic sda_rise;
	logic start_det;
	logic stop_det;

	sid_bus_sampler u_smp (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.scl       (bus.scl),
		.sda       (bus.sda),
		.scl_rise  (scl_rise),
		.scl_fall  (scl_fall),
		.sda_rise  (sda_rise),
		.start_det (start_det),
		.stop_det  (stop_det)
	);

	// =================================================================
	// decode
	wire [7:0] rom_byte  = ROM_BITS[{ptr_q[2:0], 3'h0} +: 8];
	// control byte above eight rom bytes
	wire       ctrl_sel  = (ptr_q == `SID_CTRL_LOC);
	wire [7:0] rd_byte   = ctrl_sel ? {7'h00, ctrl_q} : rom_byte;
	wire       ptr_last  = ({4'h0, ptr_q} == `SID_LAST_LOC);
	wire [3:0] ptr_next  = ptr_last ? 4'h0 : ptr_q + 4'h1;
	wire       addr_hit  = (shift_q[7:1] == SLAVE_ADDR);
	wire       valid_location   = (shift_q <= `SID_LAST_LOC);
	wire       invalid_location = ~valid_location;
	wire       data_ok   = ctrl_sel & ~bad_ptr_q;
	wire       ack_now   = (ph_q == sid_pkg::PH_SLA) |
		((ph_q == sid_pkg::PH_PTR) & valid_location) |
		((ph_q == sid_pkg::PH_DATA) & data_ok);
	wire       byte_in   = (st_q == sid_pkg::DEV_RX) & scl_fall & (bit_q == 4'h8);
	wire       tmo_clr   = sda_rise | ((scl_rise | scl_fall) & bus.sda);
	wire       tmo_hit   = ctrl_q & (tmo_cnt_q >= 32'(TIMEOUT_CYC - 1));

	// =================================================================
	// timeout counter
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tmo_cnt_q <= 32'h0000_0000;
			tmo_q     <= 1'b0;
		end else begin
			tmo_cnt_q <= (tmo_clr | tmo_hit | ~ctrl_q) ? 32'h0000_0000 : tmo_cnt_q + 32'h1;
			tmo_q     <= tmo_hit;
		end
	end

	// =================================================================
	// memory pointer and control byte
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ptr_q     <= `SID_PTR_RESET;
			ctrl_q    <= `SID_CTRL_RESET;
			bad_ptr_q <= 1'b0;
		end else if (byte_in & (ph_q == sid_pkg::PH_PTR)) begin
			bad_ptr_q <= invalid_location;
			if (valid_location) begin
				ptr_q <= shift_q[3:0];
			end
		end else if (byte_in & (ph_q == sid_pkg::PH_DATA)) begin
			if (data_ok) begin
				ctrl_q <= shift_q[0];
			end
			ptr_q <= ptr_next;
		end else if ((st_q == sid_pkg::DEV_ACK) & scl_fall & rd_q) begin
			ptr_q <= ptr_next;
		end
	end

	// =================================================================
	// serial state machine
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_q       <= sid_pkg::DEV_IDLE;
			ph_q       <= sid_pkg::PH_SLA;
			bit_q      <= 4'h0;
			shift_q    <= 8'h00;
			rd_q       <= 1'b0;
			sda_oe_n_q <= 1'b1;
			sda_o_q    <= 1'b0;
		end else if (tmo_hit) begin
			st_q       <= sid_pkg::DEV_IDLE;
			sda_oe_n_q <= 1'b1;
		end else if (start_det) begin
			st_q       <= sid_pkg::DEV_RX;
			ph_q       <= sid_pkg::PH_SLA;
			bit_q      <= 4'h0;
			sda_oe_n_q <= 1'b1;
		end else if (stop_det) begin
			st_q       <= sid_pkg::DEV_IDLE;
			sda_oe_n_q <= 1'b1;
		end else begin
			case (st_q)
				sid_pkg::DEV_RX: begin
					if (scl_rise & (bit_q != 4'h8)) begin
						shift_q <= {shift_q[6:0], bus.sda};
						bit_q   <= bit_q + 4'h1;
					end else if (byte_in) begin
						if ((ph_q == sid_pkg::PH_SLA) & ~addr_hit) begin
							st_q <= sid_pkg::DEV_IDLE;
						end else begin
							sda_oe_n_q <= ~ack_now;
							st_q       <= sid_pkg::DEV_ACK;
							if (ph_q == sid_pkg::PH_SLA) begin
								rd_q <= shift_q[0];
							end
						end
					end
				end
				sid_pkg::DEV_ACK: begin
					if (scl_fall) begin
						if (rd_q) begin
							sda_oe_n_q <= rd_byte[7];
							shift_q    <= {rd_byte[6:0], 1'b0};
							bit_q      <= 4'h1;
							st_q       <= sid_pkg::DEV_TX;
						end else begin
							sda_oe_n_q <= 1'b1;
							bit_q      <= 4'h0;
							st_q       <= sid_pkg::DEV_RX;
							ph_q       <= (ph_q == sid_pkg::PH_SLA) ? sid_pkg::PH_PTR
								: sid_pkg::PH_DATA;
						end
					end
				end
				sid_pkg::DEV_TX: begin
					if (scl_fall) begin
						if (bit_q == 4'h8) begin
							sda_oe_n_q <= 1'b1;
							st_q       <= sid_pkg::DEV_MACK;
						end else begin
							sda_oe_n_q <= shift_q[7];
							shift_q    <= {shift_q[6:0], 1'b0};
							bit_q      <= bit_q + 4'h1;
						end
					end
				end
				sid_pkg::DEV_MACK: begin
					if (scl_rise) begin
						st_q <= bus.sda ? sid_pkg::DEV_IDLE : sid_pkg::DEV_ACK;
					end
				end
				default: begin
					st_q <= sid_pkg::DEV_IDLE;
				end
			endcase
		end
	end

	// =================================================================
	// outputs
	// no scl output exists
	assign bus.dev_sda_oe_n  = sda_oe_n_q;
	assign bus.dev_sda_o     = sda_o_q;
	assign smbus_mode_select = ctrl_q;
	assign addr_ptr          = ptr_q;
	assign bus_timeout       = tmo_q;
endmodule

//--- rtl/sid_i2c_host.sv
// i2c bus master with axi4-lite command registers
`timescale 1ns/1ps
`include "sid_defines.svh"
module sid_i2c_host #(
	parameter int         AW        = 8,
	parameter logic [15:0] DIV_RESET = `SID_DIV_RESET
) (
	input  wire logic          core_clk,
	input  wire logic          rstn,
	sid_i2c_if.host            bus,
	input  wire logic          awvalid,
	output logic               awready,
	input  wire logic [AW-1:0] awaddr,
	input  wire logic          wvalid,
	output logic               wready,
	input  wire logic [31:0]   wdata,
	input  wire logic [3:0]    wstrb,
	output logic               bvalid,
	input  wire logic          bready,
	output logic [1:0]         bresp,
	input  wire logic          arvalid,
	output logic               arready,
	input  wire logic [AW-1:0] araddr,
	output logic               rvalid,
	input  wire logic          rready,
	output logic [31:0]        rdata,
	output logic [1:0]         rresp
);
	if (AW < 4 || AW > 32 || DIV_RESET < 16'h0002) begin : g_bad_param
		$error("address width or divider out of range");
	end

	sid_pkg::sid_host_state_t hst_q;
	logic [1:0]  ph_q;
	logic [3:0]  bit_q;
	logic        start_p_q, byte_p_q, wr_p_q, stop_p_q, nack_p_q;
	logic [7:0]  txd_q, rx_q;
	logic [15:0] div_q, div_cnt_q;
	logic        nack_seen_q;
	logic        aw_have_q, w_have_q;
	logic [7:0]  waddr_q;
	logic [31:0] wdat_q;
	logic [3:0]  wstb_q;
	logic        scl_q, sda_rel_q, scl_oe_n_q, sda_o_q;

	// =================================================================
	// register decode
	wire [7:0]  raddr    = 8'(araddr);
	wire        do_wr    = aw_have_q & w_have_q & ~bvalid;
	wire        hit_cmd  = (waddr_q == `SID_REG_CMD);
	wire        hit_txd  = (waddr_q == `SID_REG_TXD);
	wire        hit_div  = (waddr_q == `SID_REG_DIV);
	wire        w_mapped = hit_cmd | hit_txd | hit_div | (waddr_q == `SID_REG_STAT);
	wire        busy_w   = (hst_q != sid_pkg::H_IDLE) | start_p_q | byte_p_q | stop_p_q;
	// pointer write then read is software order
	wire        cmd_go   = do_wr & hit_cmd & wstb_q[0] & ~busy_w;
	wire [31:0] stat_w   = {22'h000000, nack_seen_q, busy_w, rx_q};
	wire        r_mapped = (raddr == `SID_REG_CMD) | (raddr == `SID_REG_TXD) |
		(raddr == `SID_REG_STAT) | (raddr == `SID_REG_DIV);
	wire [31:0] rd_word  = (raddr == `SID_REG_TXD)  ? {24'h000000, txd_q} :
		(raddr == `SID_REG_STAT) ? stat_w :
		(raddr == `SID_REG_DIV)  ? {16'h0000, div_q} : 32'h0000_0000;
	wire        tick     = (div_cnt_q >= div_q - 16'h1);
	// ack bit low unless nack asked
	wire        bit_val  = wr_p_q ? ((bit_q == 4'h8) | txd_q[3'h7 - bit_q[2:0]])
		: ((bit_q != 4'h8) | nack_p_q);

	// =================================================================
	// axi4-lite write channel
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			awready   <= 1'b1;
			wready    <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			waddr_q   <= 8'h00;
			wdat_q    <= 32'h0000_0000;
			wstb_q    <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= `SID_RESP_OKAY;
		end else begin
			if (awvalid & awready) begin
				aw_have_q <= 1'b1;
				waddr_q   <= 8'(awaddr);
				awready   <= 1'b0;
			end
			if (wvalid & wready) begin
				w_have_q <= 1'b1;
				wdat_q   <= wdata;
				wstb_q   <= wstrb;
				wready   <= 1'b0;
			end
			if (do_wr) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid    <= 1'b1;
				bresp     <= w_mapped ? `SID_RESP_OKAY : `SID_RESP_SLVERR;
			end
			if (bvalid & bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// =================================================================
	// axi4-lite read channel
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `SID_RESP_OKAY;
		end else if (arvalid & arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_word;
			rresp   <= r_mapped ? `SID_RESP_OKAY : `SID_RESP_SLVERR;
		end else if (rvalid & rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// =================================================================
	// data and divider registers
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			txd_q     <= 8'h00;
			div_q     <= DIV_RESET;
			div_cnt_q <= 16'h0000;
		end else begin
			if (do_wr & hit_txd & wstb_q[0]) begin
				txd_q <= wdat_q[7:0];
			end
			if (do_wr & hit_div & wstb_q[0]) begin
				div_q[7:0] <= wdat_q[7:0];
			end
			if (do_wr & hit_div & wstb_q[1]) begin
				div_q[15:8] <= wdat_q[15:8];
			end
			div_cnt_q <= (tick | ~busy_w) ? 16'h0000 : div_cnt_q + 16'h1;
		end
	end

	// =================================================================
	// bit sequencer, four quarter phases per bit
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			hst_q       <= sid_pkg::H_IDLE;
			ph_q        <= 2'h0;
			bit_q       <= 4'h0;
			{start_p_q, byte_p_q, wr_p_q, stop_p_q, nack_p_q} <= 5'h00;
			rx_q        <= 8'h00;
			nack_seen_q <= 1'b0;
			scl_q       <= 1'b1;
			sda_rel_q   <= 1'b1;
			scl_oe_n_q  <= 1'b0;
			sda_o_q     <= 1'b0;
		end else if (cmd_go) begin
			start_p_q   <= wdat_q[`SID_CMD_START];
			byte_p_q    <= wdat_q[`SID_CMD_WRITE] | wdat_q[`SID_CMD_READ];
			wr_p_q      <= wdat_q[`SID_CMD_WRITE];
			stop_p_q    <= wdat_q[`SID_CMD_STOP];
			nack_p_q    <= wdat_q[`SID_CMD_NACK];
			nack_seen_q <= 1'b0;
		end else if (hst_q == sid_pkg::H_IDLE) begin
			ph_q  <= 2'h0;
			bit_q <= 4'h0;
			hst_q <= start_p_q ? sid_pkg::H_START : byte_p_q ? sid_pkg::H_BITS :
				stop_p_q ? sid_pkg::H_STOP : sid_pkg::H_IDLE;
		end else if (tick) begin
			ph_q <= ph_q + 2'h1;
			case ({hst_q, ph_q})
				{sid_pkg::H_START, 2'h0}: {scl_q, sda_rel_q} <= 2'h1;
				{sid_pkg::H_START, 2'h2}: sda_rel_q <= 1'b0;
				{sid_pkg::H_BITS, 2'h0}:  {scl_q, sda_rel_q} <= {1'b0, bit_val};
				{sid_pkg::H_BITS, 2'h2}: begin
					if (wr_p_q & (bit_q == 4'h8)) begin
						nack_seen_q <= bus.sda;
					end else if (~wr_p_q & (bit_q != 4'h8)) begin
						rx_q <= {rx_q[6:0], bus.sda};
					end
				end
				{sid_pkg::H_STOP, 2'h0}:  {scl_q, sda_rel_q} <= 2'h0;
				{sid_pkg::H_STOP, 2'h2}:  sda_rel_q <= 1'b1;
				default: begin
					if (ph_q == 2'h1) begin
						scl_q <= 1'b1;
					end else if (ph_q == 2'h3 && hst_q != sid_pkg::H_STOP) begin
						scl_q <= 1'b0;
					end
				end
			endcase
			if (ph_q == 2'h3) begin
				if (hst_q == sid_pkg::H_BITS && bit_q != 4'h8) begin
					bit_q <= bit_q + 4'h1;
				end else begin
					hst_q <= sid_pkg::H_IDLE;
					case (hst_q)
						sid_pkg::H_START: start_p_q <= 1'b0;
						sid_pkg::H_BITS:  byte_p_q  <= 1'b0;
						default:          stop_p_q  <= 1'b0;
					endcase
				end
			end
		end
	end

	assign bus.host_scl_o    = scl_q;
	assign bus.host_scl_oe_n = scl_oe_n_q;
	assign bus.host_sda_o    = sda_o_q;
	assign bus.host_sda_oe_n = sda_rel_q;
endmodule

//--- dv/sid_link_assertions.sv
// wire-level checker for the serial id i2c link
`timescale 1ns/1ps
`include "sid_defines.svh"
module sid_link_assertions (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic host_scl_o,
	input wire logic host_scl_oe_n,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n,
	input wire logic scl,
	input wire logic sda
);
	logic       scl_q;
	logic       sda_q;
	logic       rd_q;
	logic [3:0] bit_q;
	logic [1:0] idx_q;
	logic [7:0] sr_q;
	wire        rise_w  = scl & ~scl_q;
	wire        start_w = scl & scl_q & sda_q & ~sda;
	wire        ack_w   = rise_w & (bit_q == 4'h8);
	wire        adr_w   = sr_q[7:1] == `SID_SLAVE_ADDR;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	// =================================================================
	// byte and ack slot tracker
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			{scl_q, sda_q, rd_q, bit_q, idx_q, sr_q} <= {2'h3, 15'h0};
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (start_w) begin
				bit_q <= 4'h0;
				idx_q <= 2'h0;
			end else if (ack_w) begin
				bit_q <= 4'h0;
				if (idx_q != 2'h3)
					idx_q <= idx_q + 2'h1;
				if (idx_q == 2'h0)
					rd_q <= sr_q[0];
			end else if (rise_w) begin
				bit_q <= bit_q + 4'h1;
				sr_q  <= {sr_q[6:0], sda};
			end
		end
	end

	// =================================================================
	// assertions
	a_addr_ack: assert property (ack_w && idx_q == 2'h0 && adr_w |-> !sda)
		else $error("own address not acked");
	a_other_addr: assert property (ack_w && idx_q == 2'h0 && !adr_w |-> sda)
		else $error("foreign address acked");
	a_ptr_ack: assert property (ack_w && idx_q == 2'h1 && !rd_q && sr_q <= 8'h08 |-> !sda)
		else $error("valid pointer not acked");
	a_ptr_refuse: assert property (ack_w && idx_q == 2'h1 && !rd_q && sr_q > 8'h08 |-> sda)
		else $error("invalid pointer acked");
	a_nack_release: assert property (ack_w && idx_q != 2'h0 && rd_q && sda |=> dev_sda_oe_n [*8])
		else $error("sda driven after master nack");
	a_drive_low: assert property (!dev_sda_oe_n |-> !dev_sda_o)
		else $error("sda driven high");
	a_sda_steady: assert property (scl && $past(scl) |-> $stable(dev_sda_oe_n))
		else $error("sda changed while scl high");
	a_scl_input: assert property (scl == (host_scl_oe_n | host_scl_o))
		else $error("scl held by device");

	c_read_nack: cover property (ack_w && rd_q && sda);
	c_bad_ptr: cover property (ack_w && idx_q == 2'h1 && sr_q > 8'h08);
	c_start: cover property (start_w);
endmodule

//--- dv/testbench.sv
// self-checking bench joining bus master and device ends
`timescale 1ns/1ps
`include "sid_defines.svh"
module testbench;
	localparam int TO = 2000;
	logic        core_clk = 0;
	logic        rstn = 0;
	logic        awvalid = 0;
	logic        wvalid = 0;
	logic        bready = 0;
	logic        arvalid = 0;
	logic        rready = 0;
	logic [7:0]  awaddr = 0;
	logic [7:0]  araddr = 0;
	logic [31:0] wdata = 0;
	logic [3:0]  wstrb = 0;
	logic        awready, wready, bvalid, arready, rvalid, mode, tmo;
	logic [1:0]  bresp, rresp, rr;
	logic [31:0] rdata, v;
	logic [3:0]  ptr;
	logic [7:0]  mem [9];
	logic [15:0] rnd = 16'h8B50;
	int          err_total = 0;
	int          total_checks = 0;
	int          mptr = 0;

	always #2.5 core_clk = ~core_clk;

	sid_i2c_if if_i ();
	sid_i2c_dev #(.TIMEOUT_CYC(TO)) sid_i2c_dev_i (.core_clk, .rstn, .bus(if_i.dev),
		.smbus_mode_select(mode), .addr_ptr(ptr), .bus_timeout(tmo));
	sid_i2c_host sid_i2c_host_i (.core_clk, .rstn, .bus(if_i.host), .awvalid, .awready,
		.awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
		.arready, .araddr, .rvalid, .rready, .rdata, .rresp);
	sid_link_assertions chk_i (.core_clk, .rstn, .host_scl_o(if_i.host_scl_o),
		.host_scl_oe_n(if_i.host_scl_oe_n), .dev_sda_o(if_i.dev_sda_o),
		.dev_sda_oe_n(if_i.dev_sda_oe_n), .scl(if_i.scl), .sda(if_i.sda));

	// =================================================================
	// helpers
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [7:0] crc8(input logic [7:0] c, d);
		for (int i = 0; i < 8; i++)
			c = (c >> 1) ^ ((c[0] ^ d[i]) ? `SID_CRC_POLY : 8'h00);
		return c;
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic hang(input int n, lim);
		if (n >= lim) begin
			err_total++;
			test_done();
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 200);
		rr = bresp;
		bready <= 1'b0;
		hang(n, 200);
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 200);
		d = rdata;
		rr = rresp;
		rready <= 1'b0;
		hang(n, 200);
	endtask
	task automatic op(input logic [7:0] cmd, tx, output logic [31:0] s);
		int n;
		n = 0;
		axi_wr(`SID_REG_TXD, {24'h0, tx});
		axi_wr(`SID_REG_CMD, {24'h0, cmd});
		do begin
			axi_rd(`SID_REG_STAT, s);
			n++;
		end while (s[8] !== 1'b0 && n < 2000);
		hang(n, 2000);
	endtask

	// =================================================================
	// i2c transfers against the model
	task automatic wseq(input logic [6:0] a, input logic [7:0] p, input bit nd, input logic [7:0] d);
		logic [31:0] s;
		op(8'h03, {a, 1'b0}, s);
		chk("addr nack", s[9], a != `SID_SLAVE_ADDR);
		if (a != `SID_SLAVE_ADDR) begin
			op(8'h08, 8'h00, s);
			return;
		end
		op(nd ? 8'h02 : 8'h0A, p, s);
		chk("ptr nack", s[9], p > 8'h08);
		if (p <= 8'h08)
			mptr = p;
		if (nd) begin
			op(8'h0A, d, s);
			chk("data nack", s[9], p != 8'h08);
			if (p == 8'h08)
				mem[8] = {7'h0, d[0]};
			mptr = (mptr + 1) % 9;
		end
		chk("ptr", ptr, mptr);
		chk("mode", mode, mem[8][0]);
	endtask
	task automatic rseq(input int cnt);
		logic [31:0] s;
		op(8'h03, {`SID_SLAVE_ADDR, 1'b1}, s);
		chk("read addr nack", s[9], 1'b0);
		for (int i = 1; i <= cnt; i++) begin
			op(i == cnt ? 8'h1C : 8'h04, 8'h00, s);
			chk("read byte", s[7:0], mem[mptr]);
			mptr = (mptr + 1) % 9;
		end
		chk("ptr", ptr, mptr);
	endtask
	task automatic tmo_watch(input logic e);
		logic t;
		t = 1'b0;
		repeat (2 * TO) @(posedge core_clk) if (tmo === 1'b1) t = 1'b1;
		chk("timeout", t, e);
	endtask

	// =================================================================
	// main sequence
	initial begin
		mem[0] = `SID_FAMILY_CODE;
		for (int i = 1; i < 7; i++)
			mem[i] = 8'(`SID_SERIAL_NUM >> (8 * (i - 1)));
		mem[7] = 8'h00;
		for (int i = 0; i < 7; i++)
			mem[7] = crc8(mem[7], mem[i]);
		mem[8] = 8'h01;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		chk("ptr", ptr, 4'h0);
		chk("mode", mode, 1'b1);
		axi_rd(`SID_REG_DIV, v);
		chk("div", v, 32'h7D);
		axi_wr(`SID_REG_DIV, 32'h4);
		axi_wr(8'h40, 32'h0);
		chk("bresp", rr, 2'h2);
		axi_rd(8'h44, v);
		chk("rresp", rr, 2'h2);
		rseq(10);
		wseq(7'h51, 8'h00, 1, 8'h00);
		rnd = lfsr(rnd);
		wseq(`SID_SLAVE_ADDR, 8'h03, 1, rnd[7:0]);
		rnd = lfsr(rnd);
		wseq(`SID_SLAVE_ADDR, 8'h08, 1, rnd[7:0] & 8'hFE);
		rseq(1);
		wseq(`SID_SLAVE_ADDR, 8'h08, 0, 8'h00);
		tmo_watch(1'b0);
		rseq(1);
		wseq(`SID_SLAVE_ADDR, 8'h09, 1, rnd[15:8]);
		wseq(`SID_SLAVE_ADDR, 8'h08, 1, 8'hFF);
		wseq(`SID_SLAVE_ADDR, 8'h05, 0, 8'h00);
		tmo_watch(1'b1);
		chk("ptr", ptr, 4'h5);
		rseq(4);
		test_done();
	end
endmodule
